// ==== core/fp_power_pkg.sv ====
/*
  Package for the front-panel power and secure-mode controller: register
  offsets, field positions, reset values, timing constants, state types.
  Assumes a 50 MHz APB clock and no other package.
*/
package fp_power_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ = 50_000_000; // Clock rate
  localparam int unsigned OVERRIDE_S = 4; // Override hold, seconds
  localparam int unsigned OVERRIDE_CYC = OVERRIDE_S * CLK_HZ; // Override hold, cycles
  localparam int unsigned DEBOUNCE_MS = 10; // Debounce time, ms
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000); // Debounce cycles
  localparam int unsigned PULSE_MS = 100; // Synthesized press width, ms
  localparam int unsigned PULSE_CYC = PULSE_MS * (CLK_HZ / 1000); // Press width, cycles
  localparam int unsigned CNT_W = 28; // Width of long counters

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [11:0] CTRL_ADDR = 12'h000; // Mode and option control
  localparam logic [11:0] SECURE_ADDR = 12'h004; // Secure-mode enables
  localparam logic [11:0] COMMAND_ADDR = 12'h008; // Management power commands
  localparam logic [11:0] STATUS_ADDR = 12'h00C; // Block state
  localparam logic [11:0] NOTIFY_ADDR = 12'h010; // Sleep-state notification

  // CTRL fields
  localparam int CTRL_ACPI = 0; // 1: ACPI mode, 0: legacy
  localparam int CTRL_TWO_BTN = 1; // 1: two-button model
  localparam int CTRL_FAN_OFF = 2; // Fans off in S1-S3
  localparam int CTRL_NOTIFY_EN = 3; // Sleep-state notification enable
  localparam int CTRL_LEG_WAKE = 4; // Legacy wake enable
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // SECURE fields
  localparam int SEC_LOCK_EN = 0; // Front panel lockout enable
  localparam int SEC_VID_EN = 1; // Video blank enable
  localparam int SEC_FLOP_EN = 2; // Floppy write protect enable
  localparam int SEC_PWR_LOCK = 3; // Power button lockout enable
  localparam int SEC_RST_LOCK = 4; // Reset button lockout enable
  localparam int SEC_OVERRIDE = 5; // Secure mode override
  localparam logic [31:0] SECURE_RESET = 32'h0000_0000;

  // COMMAND fields (write one to act)
  localparam int CMD_POWER_ON = 0; // Immediate power on
  localparam int CMD_POWER_OFF = 1; // Immediate power off
  localparam int CMD_WAKE = 2; // Management wake, simulated press

  // STATUS fields
  localparam int ST_POWER = 0; // System power on
  localparam int ST_SECURE = 1; // Secure actions active
  localparam int ST_WDOG_RUN = 2; // Watchdog running
  localparam int ST_SLEEP_LO = 4; // Sleep state field low bit
  localparam int ST_SLEEP_W = 3; // Sleep state field width

  // NOTIFY fields
  localparam int NOTIFY_PEND = 0; // Notification pending, write one to clear
  localparam int NOTIFY_STATE_LO = 4; // State to send

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    S0 = 3'h0, S1 = 3'h1, S2 = 3'h2, S3 = 3'h3, S4 = 3'h4, S5 = 3'h5
  } sleep_e;

  typedef enum {PRESS_IDLE, PRESS_HELD, PRESS_DONE} press_e;

  // Raw front-panel and wake pins
  typedef struct packed {
    logic power_btn; // Power push-button, active high
    logic sleep_btn; // Sleep push-button
    logic reset_btn; // Reset push-button
    logic ring_a; // Ring indicate, serial_port_a
    logic ring_b; // Ring indicate, serial_port_b
    logic secure_mode_request; // From keyboard controller
  } panel_in_s;

  // Secure-mode outputs
  typedef struct packed {
    logic video_blank; // Blank on-board video
    logic floppy_wp; // Write protect floppies
    logic lockout; // Lockout active
  } secure_out_s;

endpackage

// ==== core/button_filter.sv ====
/*
  Two-stage synchroniser and debouncer for one push-button, with a
  press-duration timer. Gives a one-cycle brief-press pulse on release and
  a one-cycle long-press pulse at the override threshold.
  Assumes one clock, pclk, and an asynchronous pin.
*/
`timescale 1ns/100ps
module button_filter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output logic pressed,
  output logic brief_press,
  output logic long_press
);

  // ****************************************
  // Synchroniser and debounce
  // ****************************************
  logic sync_a; // First stage, read by second only
  logic sync_b; // Second stage
  logic [fp_power_pkg::CNT_W-1:0] db_cnt; // Stable-time counter
  logic [fp_power_pkg::CNT_W-1:0] hold_cnt; // Press duration
  logic long_seen; // Override already fired this press
  wire db_done = (db_cnt == fp_power_pkg::CNT_W'(fp_power_pkg::DEBOUNCE_CYC));
  wire changed = (sync_b != pressed);
  wire hold_hit = (hold_cnt == fp_power_pkg::CNT_W'(fp_power_pkg::OVERRIDE_CYC));

  // Two flip-flops before any logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
    end
  end

  // Accept a new level only after it stayed stable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      db_cnt <= '0;
      pressed <= 1'b0;
    end else if (!changed) begin
      db_cnt <= '0;
    end else if (db_done) begin
      db_cnt <= '0;
      pressed <= sync_b;
    end else begin
      db_cnt <= db_cnt + 1'b1;
    end
  end

  // ****************************************
  // Press duration
  // ****************************************
  // Count hold time; brief press on early release, long press at threshold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt <= '0;
      long_seen <= 1'b0;
      brief_press <= 1'b0;
      long_press <= 1'b0;
    end else begin
      brief_press <= 1'b0;
      long_press <= 1'b0;
      if (pressed) begin
        if (!hold_hit) begin
          hold_cnt <= hold_cnt + 1'b1;
        end else if (!long_seen) begin
          long_seen <= 1'b1;
          long_press <= 1'b1;
        end
      end else begin
        // Released: brief only when threshold not reached
        if (hold_cnt != '0 && !long_seen) begin
          brief_press <= 1'b1;
        end
        hold_cnt <= '0;
        long_seen <= 1'b0;
      end
    end
  end

endmodule // button_filter

// ==== core/fp_power_ctrl.sv ====
/*
  Front-panel power control and secure-mode logic with an APB register
  slave. Filters buttons, runs legacy or ACPI power flow, synthesizes
  button presses to the chipset, gates wakes, stops the watchdog in
  sleep, drives fan and secure outputs, flags sleep-state notifications.
  Assumes 50 MHz pclk, chipset and keyboard-controller signals asynchronous.
*/
// Implementation choices: register access over APB and the address map.
// Summary of operation
// - Legacy mode ignores sleep button presses.
// - Legacy power press toggles power directly.
// - Legacy power press, on or off, refused under front-panel lockout with power button lockout enabled.
// - ACPI: gate real presses, synthesize presses.
// - Intercept chipset requests; RTC alarm powers up.
// - Watchdog and commands change power immediately.
// - One-button brief press running means sleep.
// - Over four seconds held forces power override.
// - Two-button: power on/off, sleep button sleeps/wakes.
// - Halt watchdog in sleep; software restarts.
// - Optional fans off in S1 to S3.
// - Flag notification on sleep state change.
// - Ring indicate wakes S1, S4, S5 or legacy.
// - Management wake is a simulated power press.
// - Legacy wake disabled out of reset.
// - Separate enables for lockout, blank, protect, buttons.
// - Override activates secure actions regardless of request.
// - Locked buttons do nothing; freed on deassert.
// - Blank and protect follow secure mode.
`timescale 1ns/100ps
module fp_power_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Front panel and wake pins
  input wire fp_power_pkg::panel_in_s panel,
  // Chipset side
  input wire logic [2:0] chipset_sleep_state,
  input wire logic chipset_power_up_req,
  input wire logic chipset_power_down_req,
  input wire logic rtc_alarm,
  output logic chipset_power_btn,
  output logic chipset_sleep_btn,
  output logic chipset_reset_btn,
  output logic power_enable,
  // Watchdog and management events, same clock
  input wire logic watchdog_power_off,
  input wire logic emergency_management_port_wake,
  input wire logic watchdog_restart,
  output logic watchdog_run,
  output logic fans_on,
  output fp_power_pkg::secure_out_s secure_out,
  output logic notify_req
);

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] ctrl; // Mode and options
  logic [31:0] secure; // Secure enables
  logic [fp_power_pkg::ST_SLEEP_W-1:0] sleep_state; // Last seen sleep state
  logic notify_pend; // Sleep change awaiting notification
  logic power_on; // System power state

  // Field decode
  wire acpi_mode = ctrl[fp_power_pkg::CTRL_ACPI];
  wire two_btn = ctrl[fp_power_pkg::CTRL_TWO_BTN];
  wire fan_off_en = ctrl[fp_power_pkg::CTRL_FAN_OFF];
  wire notify_en = ctrl[fp_power_pkg::CTRL_NOTIFY_EN];
  wire legacy_wake = ctrl[fp_power_pkg::CTRL_LEG_WAKE];

  // ****************************************
  // Synchronisers for asynchronous inputs
  // ****************************************
  localparam int NSYNC = 8; // Level inputs crossing in
  logic [NSYNC-1:0] s1; // First stage
  logic [NSYNC-1:0] s2; // Second stage
  wire [NSYNC-1:0] async_in = {chipset_sleep_state, chipset_power_up_req,
    chipset_power_down_req, rtc_alarm, panel.ring_a | panel.ring_b,
    panel.secure_mode_request};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      // Two flip-flops per level
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1[gi] <= 1'b0;
          s2[gi] <= 1'b0;
        end else begin
          s1[gi] <= async_in[gi];
          s2[gi] <= s1[gi];
        end
      end
    end
  endgenerate

  wire [2:0] cs_state = s2[7:5];
  wire cs_up = s2[4];
  wire cs_down = s2[3];
  wire rtc_sync = s2[2];
  wire ring_sync = s2[1];
  wire sec_req = s2[0];
  logic ring_d; // Ring edge detect
  logic cs_up_d; // Power-up request edge detect
  logic cs_down_d; // Power-down request edge detect
  logic rtc_d; // Alarm edge detect

  // ****************************************
  // Buttons
  // ****************************************
  logic pwr_held, pwr_brief, pwr_long;
  logic slp_held, slp_brief;
  logic rst_held;

  button_filter u_pwr (
    .pclk(pclk), .presetn(presetn), .pin(panel.power_btn),
    .pressed(pwr_held), .brief_press(pwr_brief), .long_press(pwr_long)
  );
  button_filter u_slp (
    .pclk(pclk), .presetn(presetn), .pin(panel.sleep_btn),
    .pressed(slp_held), .brief_press(slp_brief), .long_press()
  );
  button_filter u_rst (
    .pclk(pclk), .presetn(presetn), .pin(panel.reset_btn),
    .pressed(rst_held), .brief_press(), .long_press()
  );

  // ****************************************
  // Secure mode
  // ****************************************
  wire secure_active = sec_req | secure[fp_power_pkg::SEC_OVERRIDE];
  wire lock_on = secure_active & secure[fp_power_pkg::SEC_LOCK_EN];
  wire pwr_locked = lock_on & secure[fp_power_pkg::SEC_PWR_LOCK];
  wire rst_locked = lock_on & secure[fp_power_pkg::SEC_RST_LOCK];

  // ****************************************
  // Power decisions
  // ****************************************
  function automatic logic is_sleep(input logic [2:0] st);
    is_sleep = (st != 3'(fp_power_pkg::S0));
  endfunction

  function automatic logic ring_wakes(input logic [2:0] st);
    ring_wakes = (st == 3'(fp_power_pkg::S1)) || (st == 3'(fp_power_pkg::S4))
      || (st == 3'(fp_power_pkg::S5));
  endfunction

  wire sleeping = power_on & is_sleep(sleep_state);
  wire ring_edge = ring_sync & ~ring_d;
  wire ring_wake = ring_edge & (acpi_mode ? ring_wakes(sleep_state)
    : legacy_wake);
  wire asleep_or_off = sleeping | ~power_on;

  // APB access decode
  wire apb_wr = psel & penable & pwrite;
  wire cmd_wr = apb_wr & (paddr == fp_power_pkg::COMMAND_ADDR);
  wire cmd_on = cmd_wr & pwdata[fp_power_pkg::CMD_POWER_ON];
  wire cmd_off = cmd_wr & pwdata[fp_power_pkg::CMD_POWER_OFF];
  wire cmd_wake = cmd_wr & pwdata[fp_power_pkg::CMD_WAKE];

  // Management wake becomes a synthesized power press
  wire mgmt_wake = (cmd_wake | emergency_management_port_wake | ring_wake)
    & asleep_or_off;
  wire rtc_up = (rtc_sync & ~rtc_d) & ~power_on;
  wire cs_up_edge = cs_up & ~cs_up_d;
  wire cs_down_edge = cs_down & ~cs_down_d;

  // Legacy: power press toggles power, on and off refused under power button lockout
  wire leg_press = ~acpi_mode & pwr_brief & ~pwr_locked;
  wire leg_on = leg_press & ~power_on;
  wire leg_off = leg_press & power_on;

  // Forced override from held power button, both modes
  wire force_off = pwr_long & power_on & ~pwr_locked;

  wire next_power_on_set = cmd_on | leg_on | rtc_up | (acpi_mode & cs_up_edge)
    | (mgmt_wake & ~power_on);
  wire next_power_on_clr = cmd_off | watchdog_power_off | force_off | leg_off
    | (acpi_mode & cs_down_edge);

  // Power state; immediate commands take priority over button flow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_on <= 1'b0;
    end else if (cmd_off | watchdog_power_off) begin
      power_on <= 1'b0;
    end else if (cmd_on) begin
      power_on <= 1'b1;
    end else if (next_power_on_clr) begin
      power_on <= 1'b0;
    end else if (next_power_on_set) begin
      power_on <= 1'b1;
    end
  end

  // ****************************************
  // Synthesized chipset presses (sleep in ACPI only, power in both modes)
  // ****************************************
  logic [fp_power_pkg::CNT_W-1:0] pulse_cnt; // Synthesized press timer
  logic synth_pwr; // Synthesized power press
  logic synth_slp; // Synthesized sleep press
  // One-button: brief press asks for sleep while running
  wire one_sleep = ~two_btn & pwr_brief & power_on & ~sleeping;
  wire two_sleep = two_btn & slp_brief;
  wire want_slp = acpi_mode & (one_sleep | two_sleep) & ~pwr_locked;
  wire want_pwr = mgmt_wake;
  wire pulse_done = (pulse_cnt == fp_power_pkg::CNT_W'(fp_power_pkg::PULSE_CYC));

  // Hold a synthesized press for its width
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt <= '0;
      synth_pwr <= 1'b0;
      synth_slp <= 1'b0;
    end else if (synth_pwr | synth_slp) begin
      pulse_cnt <= pulse_cnt + 1'b1;
      if (pulse_done) begin
        synth_pwr <= 1'b0;
        synth_slp <= 1'b0;
        pulse_cnt <= '0;
      end
    end else begin
      synth_pwr <= want_pwr;
      synth_slp <= want_slp & ~want_pwr;
    end
  end

  // Real presses pass only in ACPI mode; real power presses also only when not locked out, sleep presses ignore lockout
  wire real_pwr = acpi_mode & pwr_held & ~pwr_locked & (two_btn | pwr_long
    | ~power_on);
  wire real_slp = acpi_mode & two_btn & slp_held & sleeping;

  // Chipset-facing outputs from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chipset_power_btn <= 1'b0;
      chipset_sleep_btn <= 1'b0;
      chipset_reset_btn <= 1'b0;
      power_enable <= 1'b0;
      fans_on <= 1'b0;
      secure_out <= '0;
    end else begin
      chipset_power_btn <= synth_pwr | real_pwr;
      chipset_sleep_btn <= synth_slp | real_slp;
      chipset_reset_btn <= rst_held & ~rst_locked;
      power_enable <= power_on;
      // Fans off in S1-S3 only when option set
      fans_on <= power_on & ~(fan_off_en & (sleep_state != 3'(fp_power_pkg::S0))
        & (sleep_state <= 3'(fp_power_pkg::S3)));
      secure_out.video_blank <= secure_active & secure[fp_power_pkg::SEC_VID_EN];
      secure_out.floppy_wp <= secure_active & secure[fp_power_pkg::SEC_FLOP_EN];
      secure_out.lockout <= lock_on;
    end
  end

  // ****************************************
  // Sleep tracking, watchdog, notification
  // ****************************************
  wire state_change = (cs_state != sleep_state);
  wire enter_sleep = state_change & is_sleep(cs_state);
  wire notify_clr = apb_wr & (paddr == fp_power_pkg::NOTIFY_ADDR)
    & pwdata[fp_power_pkg::NOTIFY_PEND];

  // Edge history, sleep state, watchdog run, notification flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ring_d <= 1'b0;
      cs_up_d <= 1'b0;
      cs_down_d <= 1'b0;
      rtc_d <= 1'b0;
      sleep_state <= '0;
      watchdog_run <= 1'b0;
      notify_pend <= 1'b0;
    end else begin
      ring_d <= ring_sync;
      cs_up_d <= cs_up;
      cs_down_d <= cs_down;
      rtc_d <= rtc_sync;
      sleep_state <= cs_state;
      // Stop on sleep entry; only software restarts
      if (enter_sleep) begin
        watchdog_run <= 1'b0;
      end else if (watchdog_restart) begin
        watchdog_run <= 1'b1;
      end
      // Set wins over clear
      if (state_change & notify_en) begin
        notify_pend <= 1'b1;
      end else if (notify_clr) begin
        notify_pend <= 1'b0;
      end
    end
  end

  assign notify_req = notify_pend;

  // ****************************************
  // APB register access
  // ****************************************
  wire sel_ctrl = (paddr == fp_power_pkg::CTRL_ADDR);
  wire sel_secure = (paddr == fp_power_pkg::SECURE_ADDR);
  wire sel_status = (paddr == fp_power_pkg::STATUS_ADDR);
  wire sel_notify = (paddr == fp_power_pkg::NOTIFY_ADDR);
  wire mapped = sel_ctrl | sel_secure | sel_status | sel_notify
    | (paddr == fp_power_pkg::COMMAND_ADDR);
  wire [31:0] status_word = {25'h0, sleep_state, 1'b0, watchdog_run,
    secure_active, power_on};
  wire [31:0] notify_word = {25'h0, sleep_state, 3'h0, notify_pend};
  wire [31:0] rd_mux = sel_ctrl ? ctrl : sel_secure ? secure
    : sel_status ? status_word : sel_notify ? notify_word : 32'h0000_0000;

  assign pready = 1'b1; // Zero wait states
  assign pslverr = psel & penable & ~mapped;

  // Writes and read data capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= fp_power_pkg::CTRL_RESET;
      secure <= fp_power_pkg::SECURE_RESET;
      prdata <= 32'h0000_0000;
    end else begin
      if (apb_wr & sel_ctrl) begin
        ctrl <= pwdata & 32'h0000_001F;
      end
      if (apb_wr & sel_secure) begin
        secure <= pwdata & 32'h0000_003F;
      end
      if (psel & ~penable & ~pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

endmodule // fp_power_ctrl

// ==== dv/fp_power_ctrl_asserts.sv ====
/* Port-level properties of fp_power_ctrl.
   Assumes a bind to fp_power_ctrl, one clock pclk, setup only over APB. */
`timescale 1ns/100ps
module fp_power_ctrl_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire fp_power_pkg::panel_in_s panel,
  input wire logic [2:0] chipset_sleep_state,
  input wire logic chipset_power_btn,
  input wire logic power_enable,
  input wire logic watchdog_power_off,
  input wire logic emergency_management_port_wake,
  input wire logic watchdog_restart,
  input wire logic watchdog_run,
  input wire logic fans_on,
  input wire fp_power_pkg::secure_out_s secure_out
);
  // ****************************************
  // Shadow of control writes
  // ****************************************
  logic [31:0] ctrl; // Copy of CTRL
  logic [31:0] sec; // Copy of SECURE
  wire logic wr = psel && penable && pwrite; // Write taken
  // Follow writes as the slave takes them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= 32'h0;
      sec <= 32'h0;
    end else if (wr && paddr == fp_power_pkg::CTRL_ADDR) begin
      ctrl <= pwdata;
    end else if (wr && paddr == fp_power_pkg::SECURE_ADDR) begin
      sec <= pwdata;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Command word with given on/off bits
  sequence cmd_write(logic [1:0] v);
    wr && paddr == fp_power_pkg::COMMAND_ADDR && pwdata[1:0] == v && !watchdog_power_off;
  endsequence
  // Blanking enabled and requested for a while
  sequence secure_held;
    (sec[1] && panel.secure_mode_request) [*8];
  endsequence
  a_cmd_on: assert property (cmd_write(2'h1) |-> ##[1:4] power_enable)
    else $error("power on command ignored");
  a_cmd_off: assert property (cmd_write(2'h2) or cmd_write(2'h3) |-> ##[1:4] !power_enable)
    else $error("power off command ignored");
  a_wdog_off: assert property (watchdog_power_off |-> ##[1:4] !power_enable)
    else $error("watchdog power off ignored");
  a_blank_on: assert property (secure_held |-> secure_out.video_blank)
    else $error("video not blanked");
  a_secure_free: assert property ((!sec[5] && !panel.secure_mode_request) [*8] |->
    secure_out == 3'h0)
    else $error("secure action left active");
  a_override_wp: assert property ((sec[5] && sec[2]) [*8] |-> secure_out.floppy_wp)
    else $error("override did not protect floppy");
  a_wdog_sleep: assert property ((chipset_sleep_state != 3'h0) [*8] |-> !watchdog_run)
    else $error("watchdog runs in sleep");
  a_no_resume: assert property ($rose(watchdog_run) |-> $past(watchdog_restart) ||
    $past(watchdog_restart, 2) || $past(watchdog_restart, 3))
    else $error("watchdog started without restart");
  a_fans_off: assert property ((ctrl[2] && chipset_sleep_state inside {3'h1, 3'h2, 3'h3}) [*8]
    |-> !fans_on)
    else $error("fans on in sleep");
  a_mgmt_wake: assert property (emergency_management_port_wake && !power_enable |->
    ##[1:4] chipset_power_btn)
    else $error("management wake gave no press");
  a_legacy_quiet: assert property (ctrl[4:0] == 5'h0 && $rose(panel.ring_a) |->
    ##1 (!chipset_power_btn) [*8])
    else $error("disabled legacy wake pressed button");
endmodule // fp_power_ctrl_asserts
bind fp_power_ctrl fp_power_ctrl_asserts fp_power_ctrl_asserts_i (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .panel, .chipset_sleep_state, .chipset_power_btn,
  .power_enable, .watchdog_power_off, .emergency_management_port_wake, .watchdog_restart,
  .watchdog_run, .fans_on, .secure_out);

// ==== dv/fp_chipset_model.sv ====
/* Far side: chipset sleep state, keyboard-controller request, ring, alarm.
   Assumes the bench sets the command inputs; outputs move after pclk. */
`timescale 1ns/100ps
module fp_chipset_model (
  input wire logic pclk,
  input wire logic secure_cmd,
  input wire logic [2:0] state_cmd,
  input wire logic ring_cmd,
  input wire logic alarm_cmd,
  output fp_power_pkg::panel_in_s panel,
  output logic [2:0] chipset_sleep_state,
  output logic rtc_alarm
);
  // Request follows secure_cmd, ring held until ring_cmd cleared
  always @(posedge pclk) begin
    panel <= {3'h0, ring_cmd, ring_cmd, secure_cmd};
    chipset_sleep_state <= state_cmd;
    rtc_alarm <= alarm_cmd;
  end
endmodule // fp_chipset_model

// ==== dv/tb_front_panel_power_secure_control.sv ====
/* Self-checking bench for fp_power_ctrl with a far-side model.
   Assumes zero-wait APB; long button timers are not exercised. */
`timescale 1ns/100ps
module tb_front_panel_power_secure_control;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, cbtn, pwr, wrun, fans, notify;
  logic [3:0] ev = 4'h0; // Pulses: wdog off, restart, alarm, wake
  logic sec_cmd = 1'b0, ring_cmd = 1'b0;
  logic [2:0] state_cmd = 3'h0, sleep_state;
  logic rtc_alarm;
  fp_power_pkg::panel_in_s panel;
  fp_power_pkg::secure_out_s sec_out;
  int mismatches = 0, num_checks = 0, ctrl_m, sec_m;
  fp_power_ctrl fp_power_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .panel, .chipset_sleep_state(sleep_state),
    .chipset_power_up_req(1'b0), .chipset_power_down_req(1'b0), .rtc_alarm,
    .chipset_power_btn(cbtn), .chipset_sleep_btn(), .chipset_reset_btn(),
    .power_enable(pwr), .watchdog_power_off(ev[0]), .emergency_management_port_wake(ev[3]),
    .watchdog_restart(ev[1]), .watchdog_run(wrun), .fans_on(fans), .secure_out(sec_out),
    .notify_req(notify));
  fp_chipset_model fp_chipset_model_i (.pclk, .secure_cmd(sec_cmd), .state_cmd,
    .ring_cmd, .alarm_cmd(ev[2]), .panel, .chipset_sleep_state(sleep_state), .rtc_alarm);
  initial forever #10 pclk = ~pclk;
  // Verdict and end of run
  task automatic final_report();
    if (mismatches == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Compare one result
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer, read data and error kept in rd and err
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      final_report();
    end
  endtask
  // One-cycle pulse helper
  task automatic pulse(input int k);
    ev <= 4'(1 << k);
    @(posedge pclk);
    ev <= 4'h0;
    repeat (6) @(posedge pclk);
  endtask
  initial begin
    void'($urandom(32'h267037C3));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, fp_power_pkg::CTRL_ADDR, 0);
    chk("ctrl", 0, rd);
    apb(0, 12'h020, 0);
    chk("bad_err", 1, err);
    repeat (4) begin
      ctrl_m = $urandom & 32'h1F;
      sec_m = $urandom & 32'h3F;
      apb(1, fp_power_pkg::CTRL_ADDR, ctrl_m);
      apb(1, fp_power_pkg::SECURE_ADDR, sec_m);
      apb(0, fp_power_pkg::CTRL_ADDR, 0);
      chk("ctrl", ctrl_m, rd);
      apb(0, fp_power_pkg::SECURE_ADDR, 0);
      chk("secure", sec_m, rd);
    end
    apb(1, fp_power_pkg::CTRL_ADDR, 0);
    sec_cmd <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1, fp_power_pkg::SECURE_ADDR, i);
      repeat (8) @(posedge pclk);
      chk("sec_out", {i[1], i[2], i[0]}, sec_out);
    end
    sec_cmd <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("sec_out", 0, sec_out);
    apb(1, fp_power_pkg::SECURE_ADDR, 32'h26);
    repeat (8) @(posedge pclk);
    chk("sec_out", 3'h6, sec_out);
    apb(1, fp_power_pkg::SECURE_ADDR, 0);
    apb(1, fp_power_pkg::COMMAND_ADDR, 1);
    repeat (4) @(posedge pclk);
    chk("power", 1, pwr);
    pulse(0);
    chk("power", 0, pwr);
    apb(1, fp_power_pkg::COMMAND_ADDR, 1);
    repeat (4) @(posedge pclk);
    apb(1, fp_power_pkg::COMMAND_ADDR, 3);
    repeat (4) @(posedge pclk);
    chk("power", 0, pwr);
    apb(1, fp_power_pkg::COMMAND_ADDR, 1);
    pulse(1);
    chk("wdog", 1, wrun);
    apb(1, fp_power_pkg::CTRL_ADDR, 32'hD);
    state_cmd <= 3'h3;
    repeat (10) @(posedge pclk);
    chk("wdog", 0, wrun);
    chk("fans", 0, fans);
    chk("notify", 1, notify);
    apb(0, fp_power_pkg::NOTIFY_ADDR, 0);
    chk("notify_reg", 32'h31, rd & 32'h71);
    apb(1, fp_power_pkg::CTRL_ADDR, 32'h9);
    repeat (10) @(posedge pclk);
    chk("fans", 1, fans);
    state_cmd <= 3'h0;
    repeat (10) @(posedge pclk);
    chk("wdog", 0, wrun);
    apb(1, fp_power_pkg::CTRL_ADDR, 0);
    apb(1, fp_power_pkg::COMMAND_ADDR, 2);
    state_cmd <= 3'h5;
    ring_cmd <= 1'b1;
    repeat (12) @(posedge pclk);
    chk("press", 0, cbtn);
    ring_cmd <= 1'b0;
    apb(1, fp_power_pkg::CTRL_ADDR, 1);
    ring_cmd <= 1'b1;
    repeat (12) @(posedge pclk);
    chk("press", 1, cbtn);
    ring_cmd <= 1'b0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    pulse(3);
    chk("press", 1, cbtn);
    pulse(0);
    pulse(2);
    chk("power", 1, pwr);
    final_report();
  end
endmodule // tb_front_panel_power_secure_control
